//--- src/nvps_defs.svh
// Purpose: timing constants for the pseudo-sram host controller
// Assumes: 100 MHz clk, 10 ns period
// Notes: least times round up to whole cycles
// How it works
// - hold chip enable low 65 ns, then high 55 ns precharge.
// - address-access read needs 135 ns low range, 120 ns high range.
// - new address held 135 or 120 ns before write strobe rises.
// - byte-select write pulse lasts at least 20 ns.
// - write strobe low 20 ns before byte selects rise.
// - page writes spaced at least 25 ns apart.
// - page write pulse low 16 ns, high 6 ns.
// - write strobe high 6 ns precharge between page pulses.
// - page read cycle at least 25 ns; word valid within 25 ns.
// - after power-up chip enable stays high 450 us.
// - chip enable high 85 ns after last access before power-off.
// - after sleep release chip enable stays high 450 us.
// - byte selects do not change while chip enable is low.
`ifndef NVPS_DEFS_SVH
`define NVPS_DEFS_SVH
`define NVPS_CLK_NS       10
`define NVPS_CUP(ns)      (((ns) + `NVPS_CLK_NS - 1) / `NVPS_CLK_NS)
`define NVPS_T_CA_NS      65
`define NVPS_T_PC_NS      55
`define NVPS_T_AA_LO_NS   135
`define NVPS_T_AA_HI_NS   120
`define NVPS_T_PAGE_NS    25
`define NVPS_T_WPP_NS     16
`define NVPS_T_WPHP_NS    6
`define NVPS_T_WP_NS      20
`define NVPS_T_PD_NS      85
`define NVPS_T_ZZL_NS     1000
`define NVPS_T_PU_US      450
`define NVPS_T_PU_CYC     (`NVPS_T_PU_US * 1000 / `NVPS_CLK_NS)
`define NVPS_SYNC_CYC     2
`endif

//--- src/nvps_pkg.sv
// Purpose: types for the pseudo-sram host controller
// Assumes: 512K x 16 array
// Notes: none
package nvps_pkg;
	typedef enum logic [1:0] {
		NVPS_OP_READ,
		NVPS_OP_WRITE,
		NVPS_OP_PAGE_READ,
		NVPS_OP_PAGE_WRITE
	} nvps_op_t;
	typedef struct packed {
		nvps_op_t    op;
		logic [18:0] addr;
		logic [15:0] wdata;
		logic [1:0]  lane_en;
	} nvps_req_t;
	typedef struct packed {
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        lb_n;
		logic        ub_n;
		logic        zz_n;
	} nvps_ctl_t;
endpackage : nvps_pkg

//--- src/nvps_host.sv
// Purpose: host controller driving a 512K x 16 nonvolatile pseudo-sram
// Assumes: 100 MHz clk; pins registered; data_bus input resynchronised
// Notes: page ops reuse the open row; req held until ack
`timescale 1ns/1ns
`include "nvps_defs.svh"
module nvps_host #(
	parameter int unsigned PU_CYC = `NVPS_T_PU_CYC
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               reset,
	// user request side
	input  wire logic               req_valid,
	input  wire nvps_pkg::nvps_req_t req,
	input  wire logic               page_last,
	input  wire logic               high_supply,
	input  wire logic               sleep_req,
	output logic                    req_ready,
	output logic                    rd_valid,
	output logic [15:0]             rd_data,
	output logic                    ready_out,
	// memory pins
	output nvps_pkg::nvps_ctl_t     pin_ctl,
	output logic [18:0]             word_address,
	output logic [15:0]             data_bus_out,
	output logic                    data_bus_oe_n,
	input  wire logic [15:0]        data_bus_in
);
	localparam logic [4:0] CA_C   = 5'(`NVPS_CUP(`NVPS_T_CA_NS));
	localparam logic [4:0] PC_C   = 5'(`NVPS_CUP(`NVPS_T_PC_NS));
	localparam logic [4:0] AALO_C = 5'(`NVPS_CUP(`NVPS_T_AA_LO_NS));
	localparam logic [4:0] AAHI_C = 5'(`NVPS_CUP(`NVPS_T_AA_HI_NS));
	localparam logic [4:0] PG_C   = 5'(`NVPS_CUP(`NVPS_T_PAGE_NS));
	localparam logic [4:0] WPP_C  = 5'(`NVPS_CUP(`NVPS_T_WPP_NS));
	localparam logic [4:0] WPH_C  = 5'(`NVPS_CUP(`NVPS_T_WPHP_NS));
	localparam logic [4:0] WP_C   = 5'(`NVPS_CUP(`NVPS_T_WP_NS));
	localparam logic [4:0] PD_C   = 5'(`NVPS_CUP(`NVPS_T_PD_NS));
	localparam logic [7:0] ZZ_C   = 8'(`NVPS_CUP(`NVPS_T_ZZL_NS));
	// read word reaches the sampler two edges late through the input flops
	localparam logic [4:0] SYNC_C = 5'(`NVPS_SYNC_CYC);

	typedef enum logic [2:0] {
		NVPS_ST_PWRUP, NVPS_ST_IDLE, NVPS_ST_ACCESS, NVPS_ST_PAGE_HI,
		NVPS_ST_PRECH, NVPS_ST_SLEEP
	} nvps_state_t;

	nvps_state_t         state_ff, nxt_state;
	logic [18:0]         wait_ff, nxt_wait;
	logic [4:0]          cnt_ff, nxt_cnt;
	nvps_pkg::nvps_ctl_t ctl_ff, nxt_ctl;
	nvps_pkg::nvps_req_t cur_ff, nxt_cur;
	logic [18:0]         addr_ff, nxt_addr;
	logic [15:0]         dout_ff, nxt_dout;
	logic                oe_ff, nxt_oe;
	logic                rdv_ff, nxt_rdv;
	logic [15:0]         rdd_ff, nxt_rdd;
	logic [15:0]         din_s1_ff, din_s2_ff;

	wire logic [4:0] aa_c     = high_supply ? AAHI_C : AALO_C;
	wire logic       is_wr    = cur_ff.op == nvps_pkg::NVPS_OP_WRITE ||
	                            cur_ff.op == nvps_pkg::NVPS_OP_PAGE_WRITE;
	wire logic       is_page  = cur_ff.op == nvps_pkg::NVPS_OP_PAGE_READ ||
	                            cur_ff.op == nvps_pkg::NVPS_OP_PAGE_WRITE;
	wire logic       wait_done = wait_ff == 19'h0_0000;
	wire logic       cnt_done  = cnt_ff == 5'h00;
	wire logic       idle_take = state_ff == NVPS_ST_IDLE && wait_done && !sleep_req;
	wire logic       page_take = state_ff == NVPS_ST_PAGE_HI && cnt_done && req_valid;

	assign req_ready = idle_take || page_take;
	assign ready_out = state_ff == NVPS_ST_IDLE && wait_done;

	always_comb begin
		nxt_state = state_ff;
		nxt_wait  = wait_done ? wait_ff : wait_ff - 19'h0_0001;
		nxt_cnt   = cnt_done ? cnt_ff : cnt_ff - 5'h01;
		nxt_ctl   = ctl_ff;
		nxt_cur   = cur_ff;
		nxt_addr  = addr_ff;
		nxt_dout  = dout_ff;
		nxt_oe    = oe_ff;
		nxt_rdv   = 1'b0;
		nxt_rdd   = rdd_ff;
		unique case (state_ff)
			NVPS_ST_PWRUP: begin
				if (wait_done) nxt_state = NVPS_ST_IDLE;
			end
			NVPS_ST_IDLE: begin
				if (wait_done && sleep_req) begin
					nxt_ctl.zz_n = 1'b0;
					nxt_cnt      = 5'h00;
					nxt_wait     = 19'(ZZ_C);
					nxt_state    = NVPS_ST_SLEEP;
				end else if (idle_take && req_valid) begin
					nxt_cur      = req;
					nxt_addr     = req.addr;
					nxt_dout     = req.wdata;
					nxt_ctl.ce_n = 1'b0;
					nxt_ctl.lb_n = !req.lane_en[0];
					nxt_ctl.ub_n = !req.lane_en[1];
					nxt_ctl.we_n = !(req.op == nvps_pkg::NVPS_OP_WRITE ||
					                 req.op == nvps_pkg::NVPS_OP_PAGE_WRITE);
					nxt_ctl.oe_n = !nxt_ctl.we_n;
					nxt_oe       = !nxt_ctl.we_n;
					// reads also wait out the input flops
					nxt_cnt      = nxt_ctl.we_n ? aa_c + SYNC_C : aa_c;
					nxt_state    = NVPS_ST_ACCESS;
				end
			end
			NVPS_ST_ACCESS: begin
				if (cnt_done) begin
					if (!is_wr) begin
						nxt_rdv = 1'b1;
						nxt_rdd = din_s2_ff;
					end
					if (is_page && !page_last) begin
						nxt_ctl.we_n = 1'b1;
						// output enable stays as is, so a page read keeps its row open
						nxt_cnt      = is_wr ? WPH_C : 5'h00;
						nxt_state    = NVPS_ST_PAGE_HI;
					end else begin
						nxt_ctl = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
						            lb_n: ctl_ff.lb_n, ub_n: ctl_ff.ub_n, zz_n: 1'b1};
						nxt_oe  = 1'b0;
						nxt_cnt = (PC_C > PD_C) ? PC_C : PD_C;
						nxt_state = NVPS_ST_PRECH;
					end
				end
			end
			NVPS_ST_PAGE_HI: begin
				if (page_take) begin
					nxt_cur.op   = cur_ff.op;
					nxt_addr     = {addr_ff[18:2], req.addr[1:0]};
					nxt_dout     = req.wdata;
					nxt_ctl.we_n = !is_wr;
					nxt_ctl.oe_n = is_wr;
					// 16 ns low + 6 ns high fits within the 25 ns page spacing
					nxt_cnt      = is_wr ? WPP_C : PG_C + SYNC_C;
					nxt_state    = NVPS_ST_ACCESS;
				end
			end
			NVPS_ST_PRECH: begin
				if (cnt_done) nxt_state = NVPS_ST_IDLE;
			end
			NVPS_ST_SLEEP: begin
				if (wait_done && !sleep_req) begin
					nxt_ctl.zz_n = 1'b1;
					nxt_wait     = 19'(PU_CYC);
					nxt_state    = NVPS_ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		din_s1_ff <= data_bus_in;
		din_s2_ff <= din_s1_ff;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= NVPS_ST_PWRUP;
			wait_ff  <= 19'(PU_CYC);
			cnt_ff   <= 5'h00;
			ctl_ff   <= '{default: 1'b1};
			cur_ff   <= '0;
			addr_ff  <= 19'h0_0000;
			dout_ff  <= 16'h0000;
			oe_ff    <= 1'b0;
			rdv_ff   <= 1'b0;
			rdd_ff   <= 16'h0000;
		end else begin
			state_ff <= nxt_state;
			wait_ff  <= nxt_wait;
			cnt_ff   <= nxt_cnt;
			ctl_ff   <= nxt_ctl;
			cur_ff   <= nxt_cur;
			addr_ff  <= nxt_addr;
			dout_ff  <= nxt_dout;
			oe_ff    <= nxt_oe;
			rdv_ff   <= nxt_rdv;
			rdd_ff   <= nxt_rdd;
		end
	end

	assign pin_ctl       = ctl_ff;
	assign word_address  = addr_ff;
	assign data_bus_out  = dout_ff;
	assign data_bus_oe_n = !oe_ff;
	assign rd_valid      = rdv_ff;
	assign rd_data       = rdd_ff;

	// chip enable low-time and high-time and sleep low-time counters for checking
	logic [7:0] ce_lo_ff, ce_hi_ff, zz_lo_ff;
	always_ff @(posedge clk) begin
		if (reset) begin
			ce_lo_ff <= 8'h00;
			ce_hi_ff <= 8'h00;
			zz_lo_ff <= 8'h00;
		end else begin
			ce_lo_ff <= ctl_ff.ce_n ? 8'h00 : (ce_lo_ff == 8'hff ? ce_lo_ff : ce_lo_ff + 8'h01);
			ce_hi_ff <= !ctl_ff.ce_n ? 8'h00 : (ce_hi_ff == 8'hff ? ce_hi_ff : ce_hi_ff + 8'h01);
			zz_lo_ff <= ctl_ff.zz_n ? 8'h00 : (zz_lo_ff == 8'hff ? zz_lo_ff : zz_lo_ff + 8'h01);
		end
	end

	a_ce_low_min: assert property (@(posedge clk) disable iff (reset)
		$rose(ctl_ff.ce_n) |-> $past(ce_lo_ff) >= 8'(CA_C - 5'h01))
		else $error("chip enable low too short");
	a_ce_prech_min: assert property (@(posedge clk) disable iff (reset)
		$fell(ctl_ff.ce_n) |-> $past(ce_hi_ff) >= 8'(PD_C - 5'h01))
		else $error("chip enable precharge too short");
	a_sleep_hold: assert property (@(posedge clk) disable iff (reset)
		$rose(ctl_ff.zz_n) |-> $past(zz_lo_ff) >= ZZ_C - 8'h01)
		else $error("sleep request too short");
	a_wr_no_oe: assert property (@(posedge clk) disable iff (reset)
		!ctl_ff.we_n |-> ctl_ff.oe_n)
		else $error("output enable during write");
	a_lane_stable: assert property (@(posedge clk) disable iff (reset)
		!ctl_ff.ce_n && !$past(ctl_ff.ce_n) |-> $stable({ctl_ff.lb_n, ctl_ff.ub_n}))
		else $error("byte select moved under chip enable");
	a_page_pulse: assert property (@(posedge clk) disable iff (reset)
		$fell(ctl_ff.we_n) && is_page |-> !ctl_ff.we_n [*2])
		else $error("page write pulse too short");
	a_page_prech: assert property (@(posedge clk) disable iff (reset)
		$rose(ctl_ff.we_n) && !ctl_ff.ce_n |=> ctl_ff.we_n)
		else $error("page precharge too short");
	a_pwrup_idle: assert property (@(posedge clk) disable iff (reset)
		state_ff == NVPS_ST_PWRUP |-> ctl_ff.ce_n)
		else $error("access during power-up hold");
	a_wake_idle: assert property (@(posedge clk) disable iff (reset)
		$rose(ctl_ff.zz_n) |-> ctl_ff.ce_n [*8])
		else $error("access too soon after sleep release");
	c_read: cover property (@(posedge clk) rd_valid);
	c_write: cover property (@(posedge clk) $fell(ctl_ff.we_n));
	c_sleep: cover property (@(posedge clk) $rose(ctl_ff.zz_n));
	c_page: cover property (@(posedge clk) page_take);
endmodule : nvps_host

//--- sim/nvps_mem_model.sv
// Purpose: behavioural model of the nonvolatile pseudo-sram
// Assumes: host pins move only on its rising edge, 10 ns clock
// Notes: a released lane shows the inverted word, there are no pulls
`timescale 1ns/1ns
module nvps_mem_model #(
	parameter int ROW_NS  = 120,
	parameter int PAGE_NS = 25
) (
	// memory pins
	input  wire nvps_pkg::nvps_ctl_t pin_ctl,
	input  wire logic [18:0]         word_address,
	input  wire logic [15:0]         data_in,
	// read drive
	output logic [15:0]              data_out
);
	logic [15:0] mem [logic [18:0]];
	logic [15:0] word = 16'h0000;
	// top bit set means no open row, so no real row matches it
	logic [17:0] row  = '1;
	logic        valid = 1'b0;
	wire rd_on = !pin_ctl.ce_n && !pin_ctl.oe_n && pin_ctl.we_n && pin_ctl.zz_n;
	wire wr_on = !pin_ctl.ce_n && !pin_ctl.we_n && pin_ctl.zz_n;
	wire lo_on = rd_on && valid && !pin_ctl.lb_n;
	wire hi_on = rd_on && valid && !pin_ctl.ub_n;
	assign data_out = {hi_on ? word[15:8] : ~word[15:8], lo_on ? word[7:0] : ~word[7:0]};
	always @(word_address or rd_on) begin
		valid <= #3 1'b0;
		word  <= #3 mem.exists(word_address) ? mem[word_address] : 16'h0000;
		if (rd_on) begin
			valid <= #(({1'b0, word_address[18:2]} == row) ? PAGE_NS : ROW_NS) 1'b1;
		end
		row = rd_on ? {1'b0, word_address[18:2]} : '1;
	end
	// sampled mid-cycle so a write never races the host's pin updates
	always #10 if (wr_on) begin
		if (!mem.exists(word_address)) mem[word_address] = 16'h0000;
		if (!pin_ctl.lb_n) mem[word_address][7:0] = data_in[7:0];
		if (!pin_ctl.ub_n) mem[word_address][15:8] = data_in[15:8];
	end
endmodule : nvps_mem_model

//--- sim/test_nv_pseudo_sram_timing.sv
// Purpose: self-checking bench for the pseudo-sram host controller
// Assumes: power-up hold shortened to 20 cycles
// Notes: single accesses from a table, page, reset and sleep by hand
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("[FAIL] %0t got %h want %h", $time, g, e); end end
module test_nv_pseudo_sram_timing;
	localparam int PU = 20;
	typedef struct {
		nvps_pkg::nvps_op_t op;
		logic [18:0]        a;
		logic [15:0]        d;
		logic [1:0]         l;
		logic [15:0]        e;
	} nvps_row_t;
	logic                clk = 1'b0, reset = 1'b1, req_valid = 1'b0, page_last = 1'b0;
	logic                high_supply = 1'b0, sleep_req = 1'b0;
	nvps_pkg::nvps_req_t req = '0;
	logic                req_ready, rd_valid, ready_out, data_bus_oe_n;
	logic [15:0]         rd_data, data_bus_out, mem_out, bus, m;
	logic [18:0]         word_address;
	nvps_pkg::nvps_ctl_t pin_ctl;
	int                  fail_count = 0, num_checks = 0, n;
	nvps_row_t rows [6] = '{
		'{nvps_pkg::NVPS_OP_WRITE, 19'h0_0010, 16'h1234, 2'b11, 16'h0000},
		'{nvps_pkg::NVPS_OP_WRITE, 19'h7_ffff, 16'ha5c3, 2'b11, 16'h0000},
		'{nvps_pkg::NVPS_OP_WRITE, 19'h0_0010, 16'hbbee, 2'b01, 16'h0000},
		'{nvps_pkg::NVPS_OP_READ,  19'h0_0010, 16'h0000, 2'b11, 16'h12ee},
		'{nvps_pkg::NVPS_OP_READ,  19'h7_ffff, 16'h0000, 2'b10, 16'ha500},
		'{nvps_pkg::NVPS_OP_READ,  19'h0_0010, 16'h0000, 2'b01, 16'h00ee}};
	assign bus = data_bus_oe_n ? mem_out : data_bus_out;
	always #5 clk = ~clk;
	nvps_host #(.PU_CYC(PU)) u_dut (.clk(clk), .reset(reset), .req_valid(req_valid),
		.req(req), .page_last(page_last), .high_supply(high_supply), .sleep_req(sleep_req),
		.req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .ready_out(ready_out),
		.pin_ctl(pin_ctl), .word_address(word_address), .data_bus_out(data_bus_out),
		.data_bus_oe_n(data_bus_oe_n), .data_bus_in(bus));
	nvps_mem_model u_mem (.pin_ctl(pin_ctl), .word_address(word_address), .data_in(bus),
		.data_out(mem_out));
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : final_report
	task automatic timeout;
		fail_count++;
		$display("[FAIL] %0t wait ran out", $time);
		final_report();
	endtask : timeout
	task automatic wait_ready;
		for (n = 0; n < 300 && req_ready !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (n == 300) timeout();
	endtask : wait_ready
	task automatic acc(input nvps_pkg::nvps_op_t op, input logic [18:0] a,
		input logic [15:0] d, input logic [1:0] l, input logic last);
		logic rd;
		rd = op == nvps_pkg::NVPS_OP_READ || op == nvps_pkg::NVPS_OP_PAGE_READ;
		req_valid = 1'b1;
		req = '{op, a, d, l};
		page_last = last;
		wait_ready();
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		// writes wait for the strobe to rise, so page_last moves between accesses
		for (n = 0; n < 100 && (rd ? rd_valid : pin_ctl.we_n) !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (n == 100) timeout();
	endtask : acc
	initial begin
		repeat (10) @(posedge clk);
		#1;
		`CHK(pin_ctl, 6'h3f)
		`CHK(req_ready, 1'b0)
		repeat (10) @(posedge clk);
		#1 reset = 1'b0;
		wait_ready();
		// one edge of slack for the release edge itself
		`CHK(n >= PU - 1, 1'b1)
		`CHK(ready_out, 1'b1)
		foreach (rows[i]) begin
			high_supply = i[0];
			acc(rows[i].op, rows[i].a, rows[i].d, rows[i].l, 1'b1);
			m = {{8{rows[i].l[1]}}, {8{rows[i].l[0]}}};
			if (rows[i].op == nvps_pkg::NVPS_OP_READ) `CHK(rd_data & m, rows[i].e)
		end
		for (int k = 0; k < 4; k++) begin
			acc(nvps_pkg::NVPS_OP_PAGE_WRITE, {17'h0_0008, 2'(k)}, {14'h3000, 2'(k)}, 2'b11,
				k == 3);
		end
		for (int k = 0; k < 4; k++) begin
			acc(nvps_pkg::NVPS_OP_PAGE_READ, {17'h0_0008, 2'(k)}, 16'h0000, 2'b11, k == 3);
			`CHK(rd_data, {14'h3000, 2'(k)})
		end
		sleep_req = 1'b1;
		for (n = 0; n < 50 && pin_ctl.zz_n !== 1'b0; n++) begin
			@(posedge clk);
			#1;
		end
		`CHK(pin_ctl.zz_n, 1'b0)
		`CHK(req_ready, 1'b0)
		`CHK(ready_out, 1'b0)
		repeat (100) @(posedge clk);
		#1 sleep_req = 1'b0;
		wait_ready();
		`CHK(n >= PU - 1, 1'b1)
		acc(nvps_pkg::NVPS_OP_READ, 19'h7_ffff, 16'h0000, 2'b11, 1'b1);
		`CHK(rd_data, 16'ha5c3)
		// reset in mid-read must drop every strobe and restart the hold
		req_valid = 1'b1;
		req = '{nvps_pkg::NVPS_OP_READ, 19'h0_0010, 16'h0000, 2'b11};
		wait_ready();
		@(posedge clk);
		#1 req_valid = 1'b0;
		repeat (3) @(posedge clk);
		#1 reset = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		`CHK(pin_ctl, 6'h3f)
		`CHK(data_bus_oe_n, 1'b1)
		`CHK(req_ready, 1'b0)
		reset = 1'b0;
		wait_ready();
		`CHK(n >= PU - 1, 1'b1)
		acc(nvps_pkg::NVPS_OP_READ, 19'h0_0010, 16'h0000, 2'b11, 1'b1);
		`CHK(rd_data, 16'h12ee)
		final_report();
	end
endmodule : test_nv_pseudo_sram_timing
